// ### rtl/sct_touch_seq.v
// switched-capacitance touch sequencer with register port
// Summary of operation
// - start clears reference capacitor, then releases switch
// - charge key, dump to reference, count cycles
// - threshold reached in the last conversion: stop, store count, set flag
// - irq shares the first touch controller vector
// - all durations counted in system clock periods
// - config: enable, prng, reference_select, threshold_select, charge_dump_time
// - reference select: 0 core, 1 high supply
// - threshold select: 0 half, 1 three quarters
// - charge and dump phases last charge_dump_time plus one
// - clear switch lasts 4+128*(zero+1)+1 clocks
// - pad clear enables pulldown zero*128 clocks
// - comparator filtered: last n samples all ones
// - repeat field sets conversions, counts accumulate 18 bits
// - command register bit layout as specified
// - flag set by hardware, cleared only by software
// - start launches sequence, self clears when done
// - count cleared on start, holds result after
`timescale 1ns/1ns
`include "sct_defs.vh"
module sct_touch_seq #(
	parameter CNT_W = `SCT_CNT_W,
	parameter PRNG_SEED = 8'hA5
) (
	input wire core_clk_in,
	input wire arst_n_in,
	input wire [`SCT_ADDR_W-1:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire cmp_in,
	output reg [7:0] reg_rdata_out,
	output reg ref_clear_sw_out,
	output reg pad_pulldown_out,
	output reg key_charge_sw_out,
	output reg key_dump_sw_out,
	output reg double_current_out,
	output reg reference_select_out,
	output reg threshold_select_out,
	output reg comparator_enable_out,
	output reg irq_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_CLEAR = 3'h1;
	localparam ST_CHARGE = 3'h2;
	localparam ST_DUMP = 3'h3;
	localparam ST_DONE = 3'h4;

	reg [7:0] config_q;
	reg [7:0] timing_q;
	reg irq_enable_q;
	reg auto_shift_q;
	reg [1:0] repeat_count_q;
	reg irq_flag_q;
	reg busy_q;
	reg [CNT_W-1:0] cycle_count_q;
	reg [CNT_W-1:0] acc_q;
	reg [2:0] state_q;
	reg [10:0] tmr_q;
	reg [2:0] conv_q;
	wire [2:0] conv_last;
	reg [7:0] prng_q;
	reg filt_clr_q;
	wire cmp_filt;
	wire [3:0] cd_time = config_q[`SCT_CFG_CDT_HI:`SCT_CFG_CDT_LO];
	wire [2:0] zero_len = timing_q[`SCT_TIM_ZERO_HI:`SCT_TIM_ZERO_LO];
	wire [10:0] clr_len;
	wire [10:0] pad_len;
	wire start_wr;
	wire done_evt;
	wire [CNT_W-1:0] acc_next;
	wire [CNT_W-1:0] result;

	// clear length 4 + 128*(zero+1) + 1, pulldown length zero*128
	assign clr_len = 11'd`SCT_CLR_PRE + ({8'h00, zero_len} + 11'h001) * 11'd`SCT_CLR_UNIT
		+ 11'd`SCT_CLR_POST;
	assign pad_len = {1'b0, zero_len, 7'h00};
	assign start_wr = reg_wr_in && (reg_addr_in == `SCT_OFF_CMD)
		&& reg_wdata_in[`SCT_CMD_GO] && !busy_q;
	assign acc_next = acc_q + 1'b1;
	// two to the repeat field conversions per start, so the shift restores one conversion
	assign conv_last = {&repeat_count_q, repeat_count_q[1], |repeat_count_q};
	// the last conversion ends when the filter is tripped at the end of a dump
	// a disabled controller never completes, so an abort leaves the flag alone
	assign done_evt = (state_q == ST_DUMP) && (tmr_q == 11'h000) && cmp_filt
		&& (conv_q == conv_last) && config_q[`SCT_CFG_EN];
	// scale back to one conversion; cost is lost low bits
	assign result = auto_shift_q ? (acc_next >> repeat_count_q) : acc_next;

	// the filter is held empty in idle and clear
	// so a stale trip from the last run cannot end a fresh conversion
	sct_cmp_filter #(
		.DEPTH_W(4)
	) u_filt (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.clr_in(filt_clr_q),
		.depth_in(timing_q[`SCT_TIM_FIL_HI:`SCT_TIM_FIL_LO]),
		.sample_in(cmp_in),
		.filt_out(cmp_filt)
	);

	// register writes and hardware-owned status bits
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			config_q <= `SCT_RST_CONFIG;
			timing_q <= `SCT_RST_TIMING;
			irq_enable_q <= 1'b0;
			auto_shift_q <= 1'b0;
			repeat_count_q <= 2'h0;
			irq_flag_q <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == `SCT_OFF_CONFIG)
				config_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `SCT_OFF_TIMING)
				timing_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `SCT_OFF_CMD) begin
				irq_enable_q <= reg_wdata_in[`SCT_CMD_IEN];
				auto_shift_q <= reg_wdata_in[`SCT_CMD_ASH];
				// repeat is held steady while a run is going
				if (!busy_q)
					repeat_count_q <= reg_wdata_in[`SCT_CMD_RPT_HI:`SCT_CMD_RPT_LO];
			end
			// writing zero clears the flag; completion in the same cycle wins
			if (done_evt)
				irq_flag_q <= 1'b1;
			else if (reg_wr_in && reg_addr_in == `SCT_OFF_CMD && !reg_wdata_in[`SCT_CMD_IRQF])
				irq_flag_q <= 1'b0;
		end
	end

	// phases of one start:
	//   clear: reference switch on for the clear length, filter held empty
	//   charge: key charge switch on for cd_time plus one clocks
	//   dump: key onto the reference for cd_time plus one clocks, one count each
	//   a filtered trip at the end of a dump ends the conversion
	//   further conversions clear the reference again and keep accumulating
	// the count register only loads at the final conversion,
	// so software never sees a partial total
	// sequencer: clear, then charge and dump until threshold, per conversion
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= ST_IDLE;
			tmr_q <= 11'h000;
			conv_q <= 3'h0;
			busy_q <= 1'b0;
			acc_q <= {CNT_W{1'b0}};
			cycle_count_q <= {CNT_W{1'b0}};
			filt_clr_q <= 1'b1;
			prng_q <= PRNG_SEED;
		end else begin
			filt_clr_q <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				filt_clr_q <= 1'b1;
				if (start_wr && config_q[`SCT_CFG_EN]) begin
					busy_q <= 1'b1;
					cycle_count_q <= {CNT_W{1'b0}};
					acc_q <= {CNT_W{1'b0}};
					conv_q <= 3'h0;
					tmr_q <= clr_len - 11'h001;
					state_q <= ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				filt_clr_q <= 1'b1;
				if (tmr_q == 11'h000) begin
					tmr_q <= {7'h00, cd_time};
					state_q <= ST_CHARGE;
				end else begin
					tmr_q <= tmr_q - 11'h001;
				end
			end
			ST_CHARGE: begin
				if (tmr_q == 11'h000) begin
					tmr_q <= {7'h00, cd_time};
					state_q <= ST_DUMP;
				end else begin
					tmr_q <= tmr_q - 11'h001;
				end
			end
			ST_DUMP: begin
				if (tmr_q == 11'h000) begin
					acc_q <= acc_next;
					// one step per charge-and-dump cycle, maximal-length sequence
					prng_q <= {prng_q[6:0], prng_q[7] ^ prng_q[5] ^ prng_q[4] ^ prng_q[3]};
					if (done_evt) begin
						cycle_count_q <= result;
						state_q <= ST_DONE;
					end else if (cmp_filt) begin
						conv_q <= conv_q + 3'h1;
						tmr_q <= clr_len - 11'h001;
						state_q <= ST_CLEAR; // next repeated conversion
					end else begin
						tmr_q <= {7'h00, cd_time};
						state_q <= ST_CHARGE;
					end
				end else begin
					tmr_q <= tmr_q - 11'h001;
				end
			end
			ST_DONE: begin
				busy_q <= 1'b0;
				filt_clr_q <= 1'b1;
				state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
			// disabling the controller aborts a run
			if (!config_q[`SCT_CFG_EN] && state_q != ST_IDLE) begin
				state_q <= ST_IDLE;
				busy_q <= 1'b0;
			end
		end
	end

	// analog controls and interrupt, all registered
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ref_clear_sw_out <= 1'b0;
			pad_pulldown_out <= 1'b0;
			key_charge_sw_out <= 1'b0;
			key_dump_sw_out <= 1'b0;
			double_current_out <= 1'b0;
			reference_select_out <= 1'b0;
			threshold_select_out <= 1'b0;
			comparator_enable_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			ref_clear_sw_out <= (state_q == ST_CLEAR);
			// pulldown runs during the leading part of the clear window
			pad_pulldown_out <= (state_q == ST_CLEAR) && timing_q[`SCT_TIM_PAD]
				&& (clr_len - 11'h001 - tmr_q < pad_len);
			key_charge_sw_out <= (state_q == ST_CHARGE);
			key_dump_sw_out <= (state_q == ST_DUMP);
			double_current_out <= config_q[`SCT_CFG_PSR] && prng_q[0];
			reference_select_out <= config_q[`SCT_CFG_REF];
			threshold_select_out <= config_q[`SCT_CFG_VTH];
			comparator_enable_out <= config_q[`SCT_CFG_EN];
			// feeds the vector shared with the first touch controller
			irq_out <= irq_flag_q && irq_enable_q;
		end
	end

	// register map, byte wide:
	//   config: enable, pseudo-random, reference, threshold, charge-dump time
	//   timing: pad clear, clear duration, filter depth
	//   command: irq enable, count top bits, auto shift, repeat, flag, start/busy
	//   count low and high bytes are read-only; writes there are ignored
	// read data one cycle after the read strobe; unmapped reads give zero
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
			`SCT_OFF_CONFIG: reg_rdata_out <= config_q;
			`SCT_OFF_TIMING: reg_rdata_out <= timing_q;
			`SCT_OFF_CMD: reg_rdata_out <= {irq_enable_q, cycle_count_q[17:16], auto_shift_q,
				repeat_count_q, irq_flag_q, busy_q};
			`SCT_OFF_CNT_LO: reg_rdata_out <= cycle_count_q[7:0];
			`SCT_OFF_CNT_HI: reg_rdata_out <= cycle_count_q[15:8];
			default: reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end
endmodule

// ### rtl/sct_defs.vh
// register offsets, field positions, reset values and timing constants of the touch sequencer
`ifndef SCT_DEFS_VH
`define SCT_DEFS_VH
`define SCT_ADDR_W 16
`define SCT_OFF_CONFIG 16'hA150
`define SCT_OFF_TIMING 16'hA151
`define SCT_OFF_CMD 16'hA152
`define SCT_OFF_CNT_LO 16'hA153
`define SCT_OFF_CNT_HI 16'hA154
`define SCT_RST_CONFIG 8'h00
`define SCT_RST_TIMING 8'h00
`define SCT_RST_CMD 8'h00
// config fields
`define SCT_CFG_EN 7
`define SCT_CFG_PSR 6
`define SCT_CFG_REF 5
`define SCT_CFG_VTH 4
`define SCT_CFG_CDT_HI 3
`define SCT_CFG_CDT_LO 0
// timing fields
`define SCT_TIM_PAD 7
`define SCT_TIM_ZERO_HI 6
`define SCT_TIM_ZERO_LO 4
`define SCT_TIM_FIL_HI 3
`define SCT_TIM_FIL_LO 0
// command fields
`define SCT_CMD_IEN 7
`define SCT_CMD_CNT_HI 6
`define SCT_CMD_CNT_LO 5
`define SCT_CMD_ASH 4
`define SCT_CMD_RPT_HI 3
`define SCT_CMD_RPT_LO 2
`define SCT_CMD_IRQF 1
`define SCT_CMD_GO 0
// clear timing in system clock periods
`define SCT_CLR_PRE 4
`define SCT_CLR_UNIT 128
`define SCT_CLR_POST 1
`define SCT_CNT_W 18
`endif

// ### rtl/sct_cmp_filter.v
// comparator digital filter: output high when the last n samples were all ones
`timescale 1ns/1ns
`include "sct_defs.vh"
module sct_cmp_filter #(
	parameter DEPTH_W = 4
) (
	input wire core_clk_in,
	input wire arst_n_in,
	input wire clr_in,
	input wire [DEPTH_W-1:0] depth_in,
	input wire sample_in,
	output reg filt_out
);
	reg [DEPTH_W:0] run_q;
	// run length of consecutive ones, saturating one above the selected depth
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			run_q <= {(DEPTH_W+1){1'b0}};
			filt_out <= 1'b0;
		end else if (clr_in || !sample_in) begin
			run_q <= {(DEPTH_W+1){1'b0}};
			filt_out <= 1'b0;
		end else begin
			if (run_q <= {1'b0, depth_in})
				run_q <= run_q + 1'b1;
			// a depth of zero still needs one high sample
			filt_out <= (run_q + 1'b1 >= {1'b0, depth_in});
		end
	end
endmodule

// ### testbench/sct_chk.sv
// port checker for the touch sequencer
`timescale 1ns/1ns
`include "sct_defs.vh"
module sct_chk (
	input wire core_clk_in,
	input wire arst_n_in,
	input wire [`SCT_ADDR_W-1:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire ref_clear_sw_out,
	input wire pad_pulldown_out,
	input wire key_charge_sw_out,
	input wire key_dump_sw_out,
	input wire reference_select_out,
	input wire threshold_select_out,
	input wire comparator_enable_out,
	input wire double_current_out,
	input wire irq_out
);
	reg [7:0] cfg_q;
	reg [7:0] tim_q;
	reg ien_q;
	reg [10:0] chg_q;
	reg [10:0] clr_q;
	reg [10:0] pad_q;
	reg [10:0] dmp_q;
	// shadow settings and run lengths; assumes no setting changes mid-conversion
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg_q <= 8'h00;
			tim_q <= 8'h00;
			ien_q <= 1'b0;
			chg_q <= 11'h000;
			clr_q <= 11'h000;
			pad_q <= 11'h000;
			dmp_q <= 11'h000;
		end else begin
			if (reg_wr_in && reg_addr_in == `SCT_OFF_CONFIG) cfg_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `SCT_OFF_TIMING) tim_q <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `SCT_OFF_CMD) ien_q <= reg_wdata_in[7];
			chg_q <= key_charge_sw_out ? chg_q + 11'h001 : 11'h000;
			clr_q <= ref_clear_sw_out ? clr_q + 11'h001 : 11'h000;
			pad_q <= pad_pulldown_out ? pad_q + 11'h001 : 11'h000;
			dmp_q <= key_dump_sw_out ? dmp_q + 11'h001 : 11'h000;
		end
	end
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	clear_first_a: assert property ($rose(key_charge_sw_out) |-> !ref_clear_sw_out)
		else $error("charge began with clear switch on");
	no_overlap_a: assert property (
		!(key_charge_sw_out && (key_dump_sw_out || ref_clear_sw_out)))
		else $error("switches overlap");
	// an abort cuts a phase short, so lengths are held only while enabled
	charge_len_a: assert property (
		$fell(key_charge_sw_out) && cfg_q[7] |-> chg_q == cfg_q[3:0] + 11'h001)
		else $error("charge phase length wrong");
	dump_len_a: assert property (
		$fell(key_dump_sw_out) && cfg_q[7] |-> dmp_q == cfg_q[3:0] + 11'h001)
		else $error("dump phase length wrong");
	clear_len_a: assert property (
		$fell(ref_clear_sw_out) && cfg_q[7] |-> clr_q == 11'h085 + {tim_q[6:4], 7'h00})
		else $error("clear length wrong");
	pad_len_a: assert property (
		$fell(pad_pulldown_out) && cfg_q[7] |-> tim_q[7] && pad_q == {tim_q[6:4], 7'h00})
		else $error("pulldown length wrong");
	ref_thr_sel_a: assert property ($changed(cfg_q) |-> ##[0:2]
		(reference_select_out == cfg_q[5] && threshold_select_out == cfg_q[4]))
		else $error("reference or threshold select wrong");
	enable_out_a: assert property (
		$changed(cfg_q) |-> ##[0:2] comparator_enable_out == cfg_q[7])
		else $error("comparator enable wrong");
	dbl_gate_a: assert property (double_current_out |-> $past(cfg_q[6]))
		else $error("double current outside pseudo-random mode");
	irq_gate_a: assert property ($rose(irq_out) |-> ien_q)
		else $error("irq raised while disabled");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	cover property ($fell(key_dump_sw_out));
	cover property ($rose(irq_out));
	cover property ($fell(pad_pulldown_out));
	cover property ($rose(double_current_out));
endmodule
bind sct_touch_seq sct_chk i_sct_chk (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ref_clear_sw_out(ref_clear_sw_out),
	.pad_pulldown_out(pad_pulldown_out), .key_charge_sw_out(key_charge_sw_out),
	.key_dump_sw_out(key_dump_sw_out), .reference_select_out(reference_select_out),
	.threshold_select_out(threshold_select_out), .comparator_enable_out(comparator_enable_out),
	.double_current_out(double_current_out),
	.irq_out(irq_out));

// ### testbench/sct_cap_model.sv
// reference capacitor and comparator as seen from the sequencer pins
`timescale 1ns/1ns
module sct_cap_model (
	input wire core_clk_in,
	input wire clear_in,
	input wire dump_in,
	input wire [7:0] target_in,
	output reg cmp_out
);
	reg [7:0] dumps_q;
	reg dump_q;
	initial begin
		dumps_q = 8'h00;
		dump_q = 1'b0;
		cmp_out = 1'b0;
	end
	// each dump adds charge; the clear switch drains it, so threshold needs target dumps
	always @(posedge core_clk_in) begin
		dump_q <= dump_in;
		if (clear_in) dumps_q <= 8'h00;
		else if (dump_in && !dump_q) dumps_q <= dumps_q + 8'h01;
		cmp_out <= !clear_in && dumps_q >= target_in;
	end
endmodule

// ### testbench/tb_sct_touch_seq.sv
// self-checking bench for the touch sequencer
`timescale 1ns/1ns
`include "sct_defs.vh"
module tb_sct_touch_seq;
	reg core_clk_in, arst_n_in, reg_wr_in, reg_rd_in, ien;
	reg [15:0] reg_addr_in;
	reg [7:0] reg_wdata_in, k, c, tm, rv;
	reg [17:0] tot;
	reg [31:0] rn;
	wire [7:0] reg_rdata_out;
	wire cmp, clr, pad, chg, dmp, dbl, rsel, tsel, cen, irq;
	integer bad_count, compares, seed, i, n;
	sct_touch_seq i_sct_touch_seq (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .cmp_in(cmp), .reg_rdata_out(reg_rdata_out),
		.ref_clear_sw_out(clr), .pad_pulldown_out(pad), .key_charge_sw_out(chg),
		.key_dump_sw_out(dmp), .double_current_out(dbl), .reference_select_out(rsel),
		.threshold_select_out(tsel), .comparator_enable_out(cen), .irq_out(irq));
	sct_cap_model i_sct_cap_model (.core_clk_in(core_clk_in), .clear_in(clr), .dump_in(dmp),
		.target_in(k), .cmp_out(cmp));
	task check(input [63:0] nm, input [17:0] e, input [17:0] g);
	begin
		compares = compares + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	// one-cycle strobes; read data sampled in the slot after the strobe
	task get(input [15:0] a);
	begin
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 rv = reg_rdata_out;
	end
	endtask
	task rd(input [15:0] a, input [7:0] e);
	begin
		get(a);
		check("register", e, rv);
	end
	endtask
	task wr(input [15:0] a, input [7:0] d);
	begin
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	end
	endtask
	task print_verdict;
	begin
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	initial begin
		seed = 60748;
		bad_count = 0;
		compares = 0;
		arst_n_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 16'h0000;
		reg_wdata_in = 8'h00;
		k = 8'h04;
		repeat (5) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		rd(`SCT_OFF_CONFIG, 8'h00);
		rd(`SCT_OFF_TIMING, 8'h00);
		rd(`SCT_OFF_CMD, 8'h00);
		rd(16'hA155, 8'h00);
		// start must be refused while the controller is disabled
		wr(`SCT_OFF_CMD, 8'h01);
		rd(`SCT_OFF_CMD, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			rn = $random(seed);
			k = 8'h02 + {5'h00, rn[2:0]};
			ien = rn[3];
			tm = {rn[11:8], 2'b00, rn[13:12]};
			wr(`SCT_OFF_CONFIG, {1'b1, rn[6:4], 4'h7});
			rd(`SCT_OFF_CONFIG, {1'b1, rn[6:4], 4'h7});
			wr(`SCT_OFF_TIMING, tm);
			rd(`SCT_OFF_TIMING, tm);
			c = {ien, 2'b00, i[2], i[1:0], 2'b11};
			wr(`SCT_OFF_CMD, c);
			rd(`SCT_OFF_CMD, c & 8'h9D);
			rd(`SCT_OFF_CNT_LO, 8'h00);
			// bounded wait for busy to fall
			n = 0;
			rv = 8'h01;
			// up to eight conversions of about 1200 clocks each fit this bound
			while (rv[0] === 1'b1 && n < 6000) begin
				get(`SCT_OFF_CMD);
				n = n + 1;
			end
			if (n == 6000) begin
				check("busy", 18'h00000, 18'h00001);
				i = 8;
			end else begin
				// two to the repeat field conversions, each ending after k dumps
				tot = {10'h000, k} << i[1:0];
				if (i[2]) tot = tot >> i[1:0];
				rd(`SCT_OFF_CNT_LO, tot[7:0]);
				rd(`SCT_OFF_CNT_HI, tot[15:8]);
				rd(`SCT_OFF_CMD, {c[7], tot[17:16], c[4:2], 2'b10});
				check("irq", ien, irq);
				wr(`SCT_OFF_CMD, c & 8'hFC);
				rd(`SCT_OFF_CMD, {c[7], tot[17:16], c[4:2], 2'b00});
				check("irq", 18'h00000, irq);
			end
		end
		// abort: dropping the enable during the clear ends the run with no flag
		wr(`SCT_OFF_CONFIG, 8'h87);
		wr(`SCT_OFF_CMD, 8'h03);
		rd(`SCT_OFF_CMD, 8'h01);
		wr(`SCT_OFF_CONFIG, 8'h07);
		rd(`SCT_OFF_CMD, 8'h00);
		rd(`SCT_OFF_CNT_LO, 8'h00);
		print_verdict;
	end
endmodule
